// [include/rsd_cfg.svh]
// Offsets, field positions, reset values and timing counts of the block
`ifndef RSD_CFG_SVH
`define RSD_CFG_SVH

// ==========================================================
// Register byte offsets
`define RSD_ADDR_CTRL 8'h00
`define RSD_ADDR_GAIN 8'h04
`define RSD_ADDR_SPEED 8'h08
`define RSD_ADDR_DUTY 8'h0c

// ==========================================================
// Control field positions
`define RSD_CTRL_SCALE_LSB 0
`define RSD_CTRL_UNIT_LSB 2
`define RSD_CTRL_SOFT_BIT 4
`define RSD_CTRL_RUN_BIT 5

// ==========================================================
// Reset values
`define RSD_SCALE_RST 2'h3
`define RSD_MANT_RST 8'ha3
`define RSD_UNIT_RST 2'h0
`define RSD_DUTY_RST 8'h00

// ==========================================================
// Gain scale values, 24 times 2^8, 2^9, 2^12, 2^13
`define RSD_SCALE_V0 18'h01800
`define RSD_SCALE_V1 18'h03000
`define RSD_SCALE_V2 18'h18000
`define RSD_SCALE_V3 18'h30000

// ==========================================================
// Back-EMF normalisation and speed unit shifts (16, 32, 64 rad/s)
`define RSD_KD_SHIFT 5'h10
`define RSD_UNIT_SH0 5'h04
`define RSD_UNIT_SH1 5'h05
`define RSD_UNIT_SH2 5'h06

// ==========================================================
// Soft start ramp timing
`define RSD_CLK_PERIOD_NS 100
`define RSD_RAMP_STEP_NS 10000
`define RSD_RAMP_STEP_CYC 8'((`RSD_RAMP_STEP_NS) / (`RSD_CLK_PERIOD_NS))

// ==========================================================
// Bus answers and divider step count
`define RSD_RESP_OKAY 2'h0
`define RSD_RESP_SLVERR 2'h2
`define RSD_DIV_STEPS 5'h1e

`endif

// [include/rsd_pkg.sv]
// Types shared by the ripple speed block
package rsd_pkg;

  // ==========================================================
  // Soft start states, Gray coded along idle, ramp, run
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RAMP = 2'h1,
    ST_RUN = 2'h3
  } rsd_ramp_t;

endpackage : rsd_pkg

// [design/rsd_div.sv]
// Sequential restoring divider for the speed estimate
`timescale 1ns/1ns
`include "rsd_cfg.svh"

module rsd_div (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Request
  input wire logic start,
  input wire logic [29:0] dividend,
  input wire logic [7:0] divisor,
  // Result
  output logic busy,
  output logic done,
  output logic [29:0] quotient
);

  logic [29:0] dvd_ff;
  logic [7:0] dvs_ff;
  logic [7:0] rem_ff;
  logic [4:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  logic [29:0] orig_ff;
  wire [8:0] trial = {rem_ff, dvd_ff[29]};
  wire fits = trial >= {1'b0, dvs_ff};
  wire [8:0] nxt_rem = fits ? trial - {1'b0, dvs_ff} : trial;

  // ==========================================================
  // One quotient bit per cycle; small area beats speed at 10 MHz
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff <= 5'h00;
    end else if (ce) begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        busy_ff <= 1'b1;
        cnt_ff <= `RSD_DIV_STEPS;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 5'h01;
        if (cnt_ff == 5'h01) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (ce && start && !busy_ff) begin
      dvd_ff <= dividend;
      orig_ff <= dividend;
      dvs_ff <= divisor;
      rem_ff <= 8'h00;
    end else if (ce && busy_ff) begin
      dvd_ff <= {dvd_ff[28:0], fits};
      rem_ff <= nxt_rem[7:0];
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;
  assign quotient = dvd_ff;

  // ==========================================================
  // Checks
  a_div_exact: assert property (
    @(posedge aclk) disable iff (!aresetn)
    done_ff |-> (39'(dvd_ff) * 39'(dvs_ff) <= 39'(orig_ff)) &&
      (39'(orig_ff) < (39'(dvd_ff) + 39'h1) * 39'(dvs_ff)))
    else $error("Divider result is not the floor quotient");

  a_div_length: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && start && !busy_ff) ##1 ce [*8] |-> busy_ff)
    else $error("Divider finished too early");

endmodule : rsd_div

// [design/rsd_ripple_speed.sv]
// Ripple speed estimate with gain scaling, soft start and AXI4-Lite registers
`timescale 1ns/1ns
`include "rsd_cfg.svh"

// Notes on behaviour
// - Gain scale 00b,01b,10b,11b means 24 times 2^8, 2^9, 2^12, 2^13.
// - Gain mantissa is an unsigned 8-bit value, zero through 255.
// - Estimate rises with gain scale and falls inversely with mantissa.
// - Gain scale resets to 11b.
// - Gain mantissa resets to 163.
// - Speed register holds a count; rad/s is count times the unit step.
// - Unit 00b gives 16 rad/s steps, 01b 32, 10b 64 rad/s steps.
// - Soft start ramps the bridge duty cycle during startup.
module rsd_ripple_speed (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Back-EMF sample stream
  input wire logic [11:0] back_emf_sample,
  input wire logic back_emf_valid,
  // Power stage
  output logic [7:0] pwm_duty
);

  // ==========================================================
  // State
  logic awready_ff, wready_ff, aw_held_ff, w_held_ff, bvalid_ff;
  logic [1:0] bresp_ff;
  logic [7:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb_ff;
  logic arready_ff, rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [1:0] back_emf_gain_scale_ff;
  logic [7:0] back_emf_gain_mantissa_ff;
  logic [1:0] unit_ff;
  logic soft_ff, run_ff;
  logic [7:0] duty_tgt_ff;
  logic [7:0] estimated_ripple_speed_ff;
  logic start_ff;
  logic [29:0] dividend_ff;
  rsd_pkg::rsd_ramp_t state_ff, nxt_state;
  logic [7:0] pwm_duty_ff, nxt_duty;
  logic [7:0] ramp_cnt_ff, nxt_cnt;
  logic div_busy, div_done;
  logic [29:0] div_q;

  // ==========================================================
  // Bus decode
  wire aw_hs = s_axi_awvalid && awready_ff;
  wire w_hs = s_axi_wvalid && wready_ff;
  wire do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
  wire b_hs = bvalid_ff && s_axi_bready;
  wire ar_hs = s_axi_arvalid && arready_ff;
  wire r_hs = rvalid_ff && s_axi_rready;
  wire wr_en = do_wr && wstrb_ff;
  wire wr_ctrl = wr_en && awaddr_ff == `RSD_ADDR_CTRL;
  wire wr_gain = wr_en && awaddr_ff == `RSD_ADDR_GAIN;
  wire wr_duty = wr_en && awaddr_ff == `RSD_ADDR_DUTY;
  wire wr_hit = awaddr_ff == `RSD_ADDR_CTRL ||
    awaddr_ff == `RSD_ADDR_GAIN || awaddr_ff == `RSD_ADDR_SPEED ||
    awaddr_ff == `RSD_ADDR_DUTY;
  wire [7:0] ar_word = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] rd_ctrl = {26'h0, run_ff, soft_ff, unit_ff,
    back_emf_gain_scale_ff};
  wire rd_hit = ar_word == `RSD_ADDR_CTRL || ar_word == `RSD_ADDR_GAIN ||
    ar_word == `RSD_ADDR_SPEED || ar_word == `RSD_ADDR_DUTY;
  wire [31:0] rd_mux =
    ar_word == `RSD_ADDR_CTRL ? rd_ctrl :
    ar_word == `RSD_ADDR_GAIN ? {24'h0, back_emf_gain_mantissa_ff} :
    ar_word == `RSD_ADDR_SPEED ? {24'h0, estimated_ripple_speed_ff} :
    ar_word == `RSD_ADDR_DUTY ? {24'h0, duty_tgt_ff} : 32'h0;

  // ==========================================================
  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RSD_RESP_OKAY;
    end else if (ce) begin
      if (aw_hs) begin
        awready_ff <= 1'b0;
        aw_held_ff <= 1'b1;
      end
      if (w_hs) begin
        wready_ff <= 1'b0;
        w_held_ff <= 1'b1;
      end
      if (do_wr) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `RSD_RESP_OKAY : `RSD_RESP_SLVERR;
      end
      if (b_hs) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (ce && aw_hs) awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
    if (ce && w_hs) begin
      wdata_ff <= s_axi_wdata[7:0];
      wstrb_ff <= s_axi_wstrb[0];
    end
  end

  // ==========================================================
  // Read channel, data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= `RSD_RESP_OKAY;
      rdata_ff <= 32'h0;
    end else if (ce) begin
      if (ar_hs) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? `RSD_RESP_OKAY : `RSD_RESP_SLVERR;
      end else if (r_hs) begin
        arready_ff <= 1'b1;
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Registers; only byte lane 0 carries fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      back_emf_gain_scale_ff <= `RSD_SCALE_RST;
      back_emf_gain_mantissa_ff <= `RSD_MANT_RST;
      unit_ff <= `RSD_UNIT_RST;
      soft_ff <= 1'b0;
      run_ff <= 1'b0;
      duty_tgt_ff <= `RSD_DUTY_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        back_emf_gain_scale_ff <= wdata_ff[`RSD_CTRL_SCALE_LSB +: 2];
        unit_ff <= wdata_ff[`RSD_CTRL_UNIT_LSB +: 2];
        soft_ff <= wdata_ff[`RSD_CTRL_SOFT_BIT];
        run_ff <= wdata_ff[`RSD_CTRL_RUN_BIT];
      end
      if (wr_gain) back_emf_gain_mantissa_ff <= wdata_ff;
      if (wr_duty) duty_tgt_ff <= wdata_ff;
    end
  end

  // ==========================================================
  // Speed estimate: sample times scale, over mantissa, in unit steps
  wire [17:0] scale_val =
    back_emf_gain_scale_ff == 2'b00 ? `RSD_SCALE_V0 :
    back_emf_gain_scale_ff == 2'b01 ? `RSD_SCALE_V1 :
    back_emf_gain_scale_ff == 2'b10 ? `RSD_SCALE_V2 :
    `RSD_SCALE_V3;
  wire [4:0] unit_sh = unit_ff == 2'b00 ? `RSD_UNIT_SH0 :
    unit_ff == 2'b01 ? `RSD_UNIT_SH1 : `RSD_UNIT_SH2;
  wire [4:0] tot_sh = `RSD_KD_SHIFT + unit_sh;
  wire [29:0] q_sh = div_q >> tot_sh;
  wire [7:0] q_sat = |q_sh[29:8] ? 8'hff : q_sh[7:0];
  wire smp_take = back_emf_valid && run_ff && !div_busy && !start_ff;
  wire mant_zero = back_emf_gain_mantissa_ff == 8'h00;

  // Samples arriving while the divider works are dropped, not queued
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_ff <= 1'b0;
      estimated_ripple_speed_ff <= 8'h00;
    end else if (ce) begin
      start_ff <= smp_take && !mant_zero;
      if (smp_take && !mant_zero)
        dividend_ff <= 30'(back_emf_sample) * 30'(scale_val);
      if (smp_take && mant_zero)
        estimated_ripple_speed_ff <= 8'hff;
      else if (div_done)
        estimated_ripple_speed_ff <= q_sat;
    end
  end

  rsd_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(start_ff),
    .dividend(dividend_ff),
    .divisor(back_emf_gain_mantissa_ff),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_q)
  );

  // ==========================================================
  // Soft start: duty climbs one count per step time to the target
  always_comb begin
    nxt_state = state_ff;
    nxt_duty = pwm_duty_ff;
    nxt_cnt = ramp_cnt_ff;
    case (state_ff)
      rsd_pkg::ST_IDLE: begin
        nxt_duty = 8'h00;
        nxt_cnt = `RSD_RAMP_STEP_CYC - 8'h01;
        if (run_ff)
          nxt_state = soft_ff ? rsd_pkg::ST_RAMP : rsd_pkg::ST_RUN;
      end
      rsd_pkg::ST_RAMP: begin
        if (!run_ff) begin
          nxt_state = rsd_pkg::ST_IDLE;
          nxt_duty = 8'h00;
        end else if (pwm_duty_ff >= duty_tgt_ff) begin
          nxt_state = rsd_pkg::ST_RUN;
          nxt_duty = duty_tgt_ff;
        end else if (ramp_cnt_ff == 8'h00) begin
          nxt_duty = pwm_duty_ff + 8'h01;
          nxt_cnt = `RSD_RAMP_STEP_CYC - 8'h01;
        end else begin
          nxt_cnt = ramp_cnt_ff - 8'h01;
        end
      end
      rsd_pkg::ST_RUN: begin
        nxt_duty = run_ff ? duty_tgt_ff : 8'h00;
        if (!run_ff) nxt_state = rsd_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = rsd_pkg::ST_IDLE;
        nxt_duty = 8'h00;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= rsd_pkg::ST_IDLE;
      pwm_duty_ff <= 8'h00;
      ramp_cnt_ff <= 8'h00;
    end else if (ce) begin
      state_ff <= nxt_state;
      pwm_duty_ff <= nxt_duty;
      ramp_cnt_ff <= nxt_cnt;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign pwm_duty = pwm_duty_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire [3:0] chk_sh = {1'b1, back_emf_gain_scale_ff[1], 1'b0,
    back_emf_gain_scale_ff[0]};

  a_scale_reset_val: assert property (
    $past(aresetn) == 1'b0 |-> back_emf_gain_scale_ff == 2'b11)
    else $error("Gain scale not 11b after reset");

  a_mant_reset_val: assert property (
    $past(aresetn) == 1'b0 |-> back_emf_gain_mantissa_ff == 8'ha3)
    else $error("Gain mantissa not 163 after reset");

  a_scale_decode: assert property (
    ce && smp_take && !mant_zero |=> dividend_ff ==
      30'($past(back_emf_sample)) * (30'h18 << $past(chk_sh)))
    else $error("Gain scale decoded to the wrong multiplier");

  a_mant_write: assert property (
    ce && wr_gain |=> back_emf_gain_mantissa_ff == $past(wdata_ff))
    else $error("Mantissa write not stored");

  a_unit_sixteen: assert property (
    ce && div_done && unit_ff == 2'b00 && div_q[29:28] == 2'b00 |=>
      estimated_ripple_speed_ff == $past(div_q[27:20]))
    else $error("Speed count wrong for 16 rad/s unit");

  a_speed_saturate: assert property (
    ce && ((div_done && |q_sh[29:8]) || (smp_take && mant_zero)) |=>
      estimated_ripple_speed_ff == 8'hff)
    else $error("Speed count did not saturate at 255");

  a_speed_readback: assert property (
    ce && ar_hs && ar_word == `RSD_ADDR_SPEED |=>
      rdata_ff == {24'h0, $past(estimated_ripple_speed_ff)})
    else $error("Speed register read returned wrong count");

  a_ramp_hold: assert property (
    ce && state_ff == rsd_pkg::ST_RAMP && run_ff &&
      pwm_duty_ff < duty_tgt_ff && ramp_cnt_ff != 8'h00 |=>
      $stable(pwm_duty_ff))
    else $error("Duty moved between ramp steps");

  a_ramp_step: assert property (
    ce && state_ff == rsd_pkg::ST_RAMP && run_ff &&
      pwm_duty_ff < duty_tgt_ff && ramp_cnt_ff == 8'h00 |=>
      pwm_duty_ff == $past(pwm_duty_ff) + 8'h01)
    else $error("Ramp step did not add one count");

  a_bvalid_hold: assert property (
    bvalid_ff && !s_axi_bready |=> bvalid_ff)
    else $error("Write response dropped before taken");

  c_write_done: cover property (ce && b_hs && bresp_ff == 2'h0);
  c_read_speed: cover property (ar_hs && ar_word == `RSD_ADDR_SPEED);
  c_saturated: cover property (div_done && |q_sh[29:8]);
  c_ramp_done: cover property (state_ff == rsd_pkg::ST_RAMP
    ##1 state_ff == rsd_pkg::ST_RUN);

endmodule : rsd_ripple_speed

// [testbench/rsd_host_model.sv]
// Host model: bus master, back-EMF source and gain tuning search
`timescale 1ns/1ns

module rsd_host_model (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic ce,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  // Sample stream
  output logic [11:0] back_emf_sample,
  output logic back_emf_valid
);
  int n_bad = 0;
  int n_chk = 0;

  initial begin
    ce = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    back_emf_sample = 12'h000;
    back_emf_valid = 1'b0;
  end

  // ==========================================================
  // Reference estimate: scale 24*2^{8,9,12,13}, unit 11b acts as 10b
  function automatic int model(int smp, int sc, int m, int u);
    longint q;
    if (m == 0) return 255;
    q = (longint'(smp) * (24 << (sc < 2 ? 8 + sc : 10 + sc))) / m;
    q = q >> (20 + (u > 2 ? 2 : u));
    return (q > 255) ? 255 : int'(q);
  endfunction : model

  // ==========================================================
  // Bus cycles; each channel is held until its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Enable low for n edges; every flop of the block must hold meanwhile
  task automatic freeze(input int n);
    @(posedge aclk);
    ce <= 1'b0;
    repeat (n) @(posedge aclk);
    ce <= 1'b1;
  endtask : freeze

  // One estimate at the given gain pair and unit, checked by a speed read 40 cycles after the sample
  task automatic est(input int smp, input int sc, input int m,
                     input int u, output int spd);
    logic [1:0] r;
    logic [31:0] d;
    wr(8'h04, 32'(m), r);
    wr(8'h00, 32'(sc + (u << 2) + 32), r);
    @(posedge aclk);
    back_emf_sample <= 12'(smp);
    back_emf_valid <= 1'b1;
    @(posedge aclk);
    back_emf_valid <= 1'b0;
    back_emf_sample <= ~12'(smp);
    repeat (40) @(posedge aclk);
    rd(8'h08, d, r);
    spd = int'(d);
    n_chk++;
    if (d !== 32'(model(smp, sc, m, u))) begin
      n_bad++;
      $display("[FAIL] %0t speed %0d at scale %0d gain %0d", $time,
               d, sc, m);
    end
  endtask : est

  // ==========================================================
  // Gain tuning search against an observed speed in rad/s
  task automatic tune(input int smp, input int obs, input int u,
                      output int sc, output int m, output bit fail);
    int e;
    int st;
    int en;
    int step;
    int it;
    bit done;
    step = 16 << (u > 2 ? 2 : u);
    fail = 0;
    done = 0;
    sc = 0;
    m = 255;
    est(smp, sc, m, u, e);
    e = e * step;
    if (e > obs) fail = 1;
    while (!fail && e < obs && sc < 3) begin
      sc++;
      est(smp, sc, m, u, e);
      e = e * step;
    end
    // Stepping back keeps the largest usable scale
    if (e > obs && sc > 0) sc--;
    st = 1;
    en = 255;
    m = 1;
    for (it = 0; it < 40 && !done && !fail; it++) begin
      est(smp, sc, m, u, e);
      e = e * step;
      if (e >= obs - step && e <= obs + step) done = 1;
      else if (sc == 3 && m == 1 && e < obs) fail = 1;
      else if (en - st <= 1) begin
        if (sc == 0) fail = 1;
        else begin
          sc--;
          st = 1;
          en = 255;
          m = 1;
        end
      end else begin
        if (e > obs) st = m;
        else en = m;
        m = (st + en + 1) / 2;
      end
    end
    if (!done) fail = 1;
  endtask : tune
endmodule : rsd_host_model

// [testbench/rsd_ripple_speed_tb.sv]
// Top testbench of the ripple speed block
`timescale 1ns/1ns

module rsd_ripple_speed_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, back_emf_valid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pwm_duty;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] back_emf_sample;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  always #50 aclk = ~aclk;

  rsd_ripple_speed i_rsd_ripple_speed (.aclk, .aresetn, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .back_emf_sample, .back_emf_valid, .pwm_duty);

  rsd_host_model i_host (.aclk, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .back_emf_sample,
    .back_emf_valid);

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
    n_tests++;
    if (got !== exp_v) begin
      error_cnt++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp_v);
    end
  endtask : chk

  task automatic stop_test();
    error_cnt = error_cnt + i_host.n_bad;
    n_tests = n_tests + i_host.n_chk;
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================================
  // Main sequence
  logic [31:0] d;
  logic [1:0] r;
  int spd, sc, m, u, a;
  bit fail;
  initial begin
    void'($urandom(65));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset contents: CTRL scale 11b, GAIN 163, SPEED and DUTY zero
    for (a = 0; a < 4; a++) begin
      i_host.rd(8'(a * 4), d, r);
      chk(d, a == 0 ? 32'h3 : a == 1 ? 32'ha3 : 32'h0);
      chk(32'(r), 32'h0);
    end
    // Unmapped place and read-only speed
    i_host.wr(8'h10, 32'hff, r);
    chk(32'(r), 32'h2);
    i_host.rd(8'h10, d, r);
    chk({d[29:0], r}, 32'h2);
    // Lane 0 strobe low: answered OKAY, mantissa left alone
    i_host.s_axi_wstrb <= 4'h0;
    i_host.wr(8'h04, 32'h11, r);
    i_host.s_axi_wstrb <= 4'hf;
    chk(32'(r), 32'h0);
    i_host.rd(8'h04, d, r);
    chk(d, 32'ha3);
    i_host.wr(8'h08, 32'h5a, r);
    chk(32'(r), 32'h0);
    i_host.rd(8'h08, d, r);
    chk(d, 32'h0);
    // Every scale and unit, boundary and random mantissas
    for (sc = 0; sc < 4; sc++) begin
      for (u = 0; u < 4; u++) begin
        m = (u == 0) ? 1 : int'($urandom_range(255, 1));
        i_host.est(int'($urandom_range(4095, 0)), sc, m, u, spd);
      end
      i_host.est(4095, sc, 255, 0, spd);
    end
    i_host.est(100, 3, 0, 0, spd);
    // Tuning searches: one stays at the top scale, one steps back
    i_host.tune(4095, 1000, 0, sc, m, fail);
    chk({31'h0, fail}, 32'h0);
    chk(32'(sc * 256 + m), 32'(3 * 256 + 12));
    i_host.tune(4095, 40, 0, sc, m, fail);
    chk(32'(sc * 256 + m + fail), 32'(2 * 256 + 128));
    // Direct start, then stop
    i_host.wr(8'h00, 32'h0, r);
    i_host.wr(8'h0c, 32'd200, r);
    i_host.wr(8'h00, 32'h20, r);
    repeat (4) @(posedge aclk);
    chk(32'(pwm_duty), 32'd200);
    i_host.wr(8'h00, 32'h0, r);
    repeat (3) @(posedge aclk);
    chk(32'(pwm_duty), 32'h0);
    // Soft start ramps one step per 100 cycles up to the target
    i_host.wr(8'h0c, 32'd3, r);
    i_host.wr(8'h00, 32'h30, r);
    repeat (50) @(posedge aclk);
    chk(32'(pwm_duty > 8'd1), 32'h0);
    repeat (100) @(posedge aclk);
    chk(32'(pwm_duty inside {8'd1, 8'd2}), 32'h1);
    // Enable low stalls the ramp; it resumes where it stopped
    i_host.freeze(200);
    chk(32'(pwm_duty), 32'd1);
    repeat (250) @(posedge aclk);
    chk(32'(pwm_duty), 32'd3);
    stop_test();
  end
endmodule : rsd_ripple_speed_tb
